// File: hw/sop_consts.vh
// Purpose: constants for the stack operator execution block
// Assumes: 51-bit stack words, tag in bits 50:48
// Notes: tag codes and descriptor/control-word field places are plain defaults
`ifndef SOP_CONSTS_VH
`define SOP_CONSTS_VH

`define SOP_TAG_SP 3'h0
`define SOP_TAG_IRW 3'h1
`define SOP_TAG_DP 3'h2
`define SOP_TAG_DD 3'h5
`define SOP_TAG_CW 3'h7

`define SOP_MSIGN 46
`define SOP_ESIGN 45
`define SOP_EXP_MSB 44
`define SOP_EXP_LSB 39
`define SOP_DD_INDEX 45
`define SOP_DD_DP 40
`define SOP_LEN_MSB 39
`define SOP_LEN_LSB 20
`define SOP_CW_SYL_MSB 15
`define SOP_CW_SYL_LSB 13
`define SOP_CW_IDX_MSB 12

`define SOP_EXP_MAX 16'sh003F
`define SOP_EXP_MIN (-16'sh003F)
`define SOP_ROUND_DIGIT 3'h4
`define SOP_DYN_IDX_MAX 39'h00_0000_4000
`define SOP_SYL_PER_WORD 3'h6
`define SOP_BRANCH_STEP 3'h3
`define SOP_SYL_ODD 3'h3

`define SOP_OP_RINT 8'h87
`define SOP_OP_SGLT 8'hCC
`define SOP_OP_SGLR 8'hCD
`define SOP_OP_XDBL 8'hCE
`define SOP_OP_AND 8'h90
`define SOP_OP_OR 8'h91
`define SOP_OP_NOT 8'h92
`define SOP_OP_EQV 8'h93
`define SOP_OP_SAME 8'h94
`define SOP_OP_GT 8'h8A
`define SOP_OP_GE 8'h89
`define SOP_OP_EQ 8'h8C
`define SOP_OP_LE 8'h8B
`define SOP_OP_LT 8'h88
`define SOP_OP_NE 8'h8D
`define SOP_OP_BRF 8'hA0
`define SOP_OP_BRT 8'hA1
`define SOP_OP_BRU 8'hA2
`define SOP_OP_DBF 8'hA8
`define SOP_OP_DBT 8'hA9

`define SOP_REG_A_LO 8'h00
`define SOP_REG_A_HI 8'h04
`define SOP_REG_B_LO 8'h08
`define SOP_REG_B_HI 8'h0C
`define SOP_REG_Y_LO 8'h10
`define SOP_REG_Y_HI 8'h14
`define SOP_REG_CTRL 8'h18
`define SOP_REG_STAT 8'h1C
`define SOP_REG_PROG 8'h20

`define SOP_F_INTOVF 0
`define SOP_F_EXPOVF 1
`define SOP_F_EXPUNF 2
`define SOP_F_INVOP 3
`define SOP_F_INVIDX 4
`define SOP_F_INDIR 5

`endif

// File: hw/sop_norm.v
// Purpose: normalize a two-word mantissa, one octal digit per step
// Assumes: mantissa is an integer, value = mantissa * 8^exponent
// Notes: a zero mantissa passes unchanged
`timescale 1ns/1ps
module sop_norm (
  input wire [77:0] m_in,
  input wire signed [15:0] e_in,
  output reg [77:0] m_out,
  output reg signed [15:0] e_out
);

integer i;

always @*
begin
  m_out = m_in;
  e_out = e_in;
  for (i = 0; i < 25; i = i + 1)
  begin
    if (m_out != 78'h0 && m_out[77:75] == 3'h0)
    begin
      m_out = {m_out[74:0], 3'h0};
      e_out = e_out - 16'sh0001;
    end
  end
end

endmodule

// File: hw/sop_exec.v
// Purpose: executes integerize, type transfer, logical, relational and branch operators
// Assumes: APB3 slave, one wait state per transfer, one execute cycle per operator
// Notes: stack words are loaded and read back as two 32-bit halves
// Contract
// - Integerize rounded 87: make B integer, round if dropped digit above 4.
// - Exponent beyond leading zeros: integer overflow, stop operator.
// - Rounding adds one; non-integer result raises integer overflow.
// - CC on unindexed double descriptor: clear double bit, double length.
// - Double to single: exponent above 63 overflow, below -63 underflow, stop.
// - CC in range: normalize, set B tag single.
// - CC and CE: word neither operand nor descriptor raises invalid operand.
// - Single operand in either single conversion: normalize only, no rounding.
// - CD rounds B from Y, clears Y; carry adjusts, exponent rechecked.
// - CE: double unchanged; single gets double tag and zero Y.
// - CE on descriptor with index and double bits clear: set double, halve length.
// - AND 90 into B; B tag kept unless A double.
// - OR 91 into B; second item tag kept unless A double.
// - Negate 92 complements A except its tag.
// - Equivalence 93: one where bits match; tags as OR.
// - Same 94 compares all bits with tags; B gets bit zero or zero.
// - Compare B against A: greater 8A, greater-equal 89, equal 8C.
// - Less-equal 8B, less 88, not-equal 8D give integer one or zero.
// - Static branches A0/A1 test A bit zero, A2 always taken; taken loads target, else advance three.
// - Target: top three bits to syllable, low 13 to index, mark program empty.
// - Dynamic A8/A9 test B bit zero; control word in A gives target.
// - Operand target: integerize, reject negative or above 16384, bit zero picks syllable.
// - Missing or wrong stack words raise invalid operand and stop.
`timescale 1ns/1ps
`include "sop_consts.vh"
module sop_exec (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

localparam ST_IDLE = 2'b01;
localparam ST_EXEC = 2'b10;

reg [1:0] st_r;
reg [50:0] a_r;
reg [50:0] b_r;
reg [50:0] y_r;
reg a_full_r;
reg b_full_r;
reg [19:0] pwi_r;
reg [2:0] psy_r;
reg p_empty_r;
reg [7:0] op_r;
reg [15:0] syl_r;
reg [5:0] flag_r;

reg [50:0] a_nxt;
reg [50:0] b_nxt;
reg [50:0] y_nxt;
reg a_full_nxt;
reg b_full_nxt;
reg [19:0] pwi_nxt;
reg [2:0] psy_nxt;
reg p_empty_nxt;
reg [5:0] set_nxt;
reg [31:0] rd_val;
reg rd_ok;

// Integer value of a single word: {overflow, magnitude}
function [39:0] f_intg;
  input [47:0] w;
  reg [77:0] sh;
  reg [7:0] amt;
  reg [39:0] sum;
  begin
    amt = {1'b0, w[44:39], 1'b0} + {2'b00, w[44:39]};
    sh = 78'h0;
    f_intg = 40'h0;
    if (!w[`SOP_ESIGN])
    begin
      sh = {39'h0, w[38:0]} << amt;
      f_intg = {(sh[77:39] != 39'h0), sh[38:0]};
    end
    else
    begin
      sh = {w[38:0], 39'h0} >> amt;
      sum = {1'b0, sh[77:39]} + {39'h0, (sh[38:36] > `SOP_ROUND_DIGIT)};
      f_intg = sum;
    end
  end
endfunction

// Build a single word from sign, signed exponent and mantissa
function [47:0] f_pack;
  input ms;
  input signed [15:0] e;
  input [38:0] m;
  reg [15:0] mag;
  begin
    mag = (e < 16'sh0000) ? -e : e;
    f_pack = {1'b0, ms, (e < 16'sh0000), mag[5:0], m};
  end
endfunction

wire [2:0] a_tag = a_r[50:48];
wire [2:0] b_tag = b_r[50:48];
wire a_dp = (a_tag == `SOP_TAG_DP);
wire b_dp = (b_tag == `SOP_TAG_DP);
wire a_is_op = (a_tag == `SOP_TAG_SP) || a_dp;
wire b_is_op = (b_tag == `SOP_TAG_SP) || b_dp;
wire b_is_dd = (b_tag == `SOP_TAG_DD);

wire [15:0] a_emag = {10'h0, a_r[44:39]};
wire [15:0] b_emag = b_dp ? {1'b0, y_r[47:39], b_r[44:39]} : {10'h0, b_r[44:39]};
wire signed [15:0] a_exp = a_r[`SOP_ESIGN] ? -a_emag : a_emag;
wire signed [15:0] b_exp = b_r[`SOP_ESIGN] ? -b_emag : b_emag;

wire [77:0] nb_m;
wire signed [15:0] nb_e;
wire [77:0] na_m;
wire signed [15:0] na_e;

sop_norm u_norm_b (
  .m_in({b_r[38:0], (b_dp ? y_r[38:0] : 39'h0)}),
  .e_in(b_exp),
  .m_out(nb_m),
  .e_out(nb_e)
);

sop_norm u_norm_a (
  .m_in({a_r[38:0], 39'h0}),
  .e_in(a_exp),
  .m_out(na_m),
  .e_out(na_e)
);

// Rounding from the extension digits; a carry renormalizes one digit
wire rnd_up = (nb_m[38:36] >= `SOP_ROUND_DIGIT);
wire [39:0] rnd_sum = {1'b0, nb_m[77:39]} + {39'h0, rnd_up};
wire [38:0] rnd_m = rnd_sum[39] ? {3'h1, 36'h0} : rnd_sum[38:0];
wire signed [15:0] rnd_e = rnd_sum[39] ? nb_e + 16'sh0001 : nb_e;

wire [39:0] b_int = f_intg(b_r[47:0]);
wire [39:0] a_int = f_intg(a_r[47:0]);

// Algebraic ordering on normalized values; all zeros compare equal
wire a_zero = (na_m[77:39] == 39'h0);
wire b_zero = (nb_m[77:39] == 39'h0);
wire a_neg = !a_zero && a_r[`SOP_MSIGN];
wire b_neg = !b_zero && b_r[`SOP_MSIGN];
wire mag_eq = (a_zero && b_zero) || (na_e == nb_e && na_m[77:39] == nb_m[77:39]);
wire b_mag_gt = !b_zero && (a_zero || nb_e > na_e || (nb_e == na_e && nb_m[77:39] > na_m[77:39]));
wire cmp_eq = mag_eq && (a_neg == b_neg);
wire cmp_gt = (a_neg != b_neg) ? a_neg : (b_neg ? (!b_mag_gt && !mag_eq) : b_mag_gt);

wire [2:0] lg_tag = a_dp ? `SOP_TAG_DP : b_tag;
wire [50:0] one_w = {`SOP_TAG_SP, 48'h1};

// One bit wider than the syllable number so that 5 + 3 does not wrap to 0
wire [3:0] psy_step = {1'b0, psy_r} + {1'b0, `SOP_BRANCH_STEP};

wire wr_en = psel && penable && pready && pwrite;

always @*
begin
  rd_ok = 1'b1;
  rd_val = 32'h0;
  if (paddr == `SOP_REG_A_LO)
    rd_val = a_r[31:0];
  else if (paddr == `SOP_REG_A_HI)
    rd_val = {13'h0, a_r[50:32]};
  else if (paddr == `SOP_REG_B_LO)
    rd_val = b_r[31:0];
  else if (paddr == `SOP_REG_B_HI)
    rd_val = {13'h0, b_r[50:32]};
  else if (paddr == `SOP_REG_Y_LO)
    rd_val = y_r[31:0];
  else if (paddr == `SOP_REG_Y_HI)
    rd_val = {13'h0, y_r[50:32]};
  else if (paddr == `SOP_REG_CTRL)
    rd_val = {8'h0, syl_r, op_r};
  else if (paddr == `SOP_REG_STAT)
    rd_val = {21'h0, st_r[1], b_full_r, a_full_r, 2'b00, flag_r};
  else if (paddr == `SOP_REG_PROG)
    rd_val = {8'h0, p_empty_r, psy_r, pwi_r};
  else
    rd_ok = 1'b0;
end

// Operator datapath, evaluated in the execute cycle
always @*
begin
  a_nxt = a_r;
  b_nxt = b_r;
  y_nxt = y_r;
  a_full_nxt = a_full_r;
  b_full_nxt = b_full_r;
  pwi_nxt = pwi_r;
  psy_nxt = psy_r;
  p_empty_nxt = p_empty_r;
  set_nxt = 6'h0;
  case (op_r)
    `SOP_OP_RINT:
    begin
      if (!b_full_r || !b_is_op)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else if (b_int[39])
        set_nxt[`SOP_F_INTOVF] = 1'b1;
      else
        b_nxt = {`SOP_TAG_SP, f_pack(b_r[`SOP_MSIGN], 16'sh0000, b_int[38:0])};
    end
    `SOP_OP_SGLT, `SOP_OP_SGLR:
    begin
      if (!b_full_r || !(b_is_op || b_is_dd))
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else if (b_is_dd)
      begin
        b_nxt[`SOP_DD_DP] = 1'b0;
        if (b_r[`SOP_DD_DP] && !b_r[`SOP_DD_INDEX])
          b_nxt[`SOP_LEN_MSB:`SOP_LEN_LSB] = {b_r[`SOP_LEN_MSB-1:`SOP_LEN_LSB], 1'b0};
      end
      else if (!b_dp)
        b_nxt[47:0] = f_pack(b_r[`SOP_MSIGN], nb_e, nb_m[77:39]);
      else if (op_r == `SOP_OP_SGLT)
      begin
        if (nb_e > `SOP_EXP_MAX)
          set_nxt[`SOP_F_EXPOVF] = 1'b1;
        else if (nb_e < `SOP_EXP_MIN)
          set_nxt[`SOP_F_EXPUNF] = 1'b1;
        else
          b_nxt = {`SOP_TAG_SP, f_pack(b_r[`SOP_MSIGN], nb_e, nb_m[77:39])};
      end
      else
      begin
        if (rnd_e > `SOP_EXP_MAX)
          set_nxt[`SOP_F_EXPOVF] = 1'b1;
        else if (rnd_e < `SOP_EXP_MIN)
          set_nxt[`SOP_F_EXPUNF] = 1'b1;
        else
        begin
          b_nxt = {`SOP_TAG_SP, f_pack(b_r[`SOP_MSIGN], rnd_e, rnd_m)};
          y_nxt = 51'h0;
        end
      end
    end
    `SOP_OP_XDBL:
    begin
      if (!b_full_r || !(b_is_op || b_is_dd))
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else if (b_is_dd)
      begin
        b_nxt[`SOP_DD_DP] = 1'b1;
        if (!b_r[`SOP_DD_DP] && !b_r[`SOP_DD_INDEX])
          b_nxt[`SOP_LEN_MSB:`SOP_LEN_LSB] = {1'b0, b_r[`SOP_LEN_MSB:`SOP_LEN_LSB+1]};
      end
      else if (!b_dp)
      begin
        b_nxt[50:48] = `SOP_TAG_DP;
        y_nxt = 51'h0;
      end
    end
    `SOP_OP_AND, `SOP_OP_OR, `SOP_OP_EQV:
    begin
      if (!a_full_r || !b_full_r)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else
      begin
        a_full_nxt = 1'b0;
        if (op_r == `SOP_OP_AND)
          b_nxt = {lg_tag, a_r[47:0] & b_r[47:0]};
        else if (op_r == `SOP_OP_OR)
          b_nxt = {lg_tag, a_r[47:0] | b_r[47:0]};
        else
          b_nxt = {lg_tag, ~(a_r[47:0] ^ b_r[47:0])};
      end
    end
    `SOP_OP_NOT:
    begin
      if (!a_full_r)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else
        a_nxt = {a_tag, ~a_r[47:0]};
    end
    `SOP_OP_SAME:
    begin
      if (!a_full_r || !b_full_r)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else
      begin
        a_full_nxt = 1'b0;
        b_nxt = (a_r == b_r) ? one_w : 51'h0;
      end
    end
    `SOP_OP_GT, `SOP_OP_GE, `SOP_OP_EQ, `SOP_OP_LE, `SOP_OP_LT, `SOP_OP_NE:
    begin
      if (!a_full_r || !b_full_r || !a_is_op || !b_is_op)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else
      begin
        a_full_nxt = 1'b0;
        b_nxt = 51'h0;
        if (op_r == `SOP_OP_GT && cmp_gt)
          b_nxt = one_w;
        else if (op_r == `SOP_OP_GE && (cmp_gt || cmp_eq))
          b_nxt = one_w;
        else if (op_r == `SOP_OP_EQ && cmp_eq)
          b_nxt = one_w;
        else if (op_r == `SOP_OP_LE && !cmp_gt)
          b_nxt = one_w;
        else if (op_r == `SOP_OP_LT && !cmp_gt && !cmp_eq)
          b_nxt = one_w;
        else if (op_r == `SOP_OP_NE && !cmp_eq)
          b_nxt = one_w;
      end
    end
    `SOP_OP_BRF, `SOP_OP_BRT, `SOP_OP_BRU:
    begin
      if (op_r != `SOP_OP_BRU && !a_full_r)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else
      begin
        if (op_r != `SOP_OP_BRU)
          a_full_nxt = 1'b0;
        if (op_r == `SOP_OP_BRU || (op_r == `SOP_OP_BRT) == a_r[0])
        begin
          psy_nxt = syl_r[15:13];
          pwi_nxt = {7'h0, syl_r[12:0]};
          p_empty_nxt = 1'b1;
        end
        else if (psy_step >= {1'b0, `SOP_SYL_PER_WORD})
        begin
          psy_nxt = psy_step[2:0] - `SOP_SYL_PER_WORD;
          pwi_nxt = pwi_r + 20'h00001;
        end
        else
          psy_nxt = psy_step[2:0];
      end
    end
    `SOP_OP_DBF, `SOP_OP_DBT:
    begin
      if (!a_full_r || !b_full_r)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else if ((op_r == `SOP_OP_DBT) != b_r[0])
      begin
        a_full_nxt = 1'b0;
        b_full_nxt = 1'b0;
      end
      else if (a_tag == `SOP_TAG_CW)
      begin
        a_full_nxt = 1'b0;
        b_full_nxt = 1'b0;
        psy_nxt = a_r[`SOP_CW_SYL_MSB:`SOP_CW_SYL_LSB];
        pwi_nxt = {7'h0, a_r[`SOP_CW_IDX_MSB:0]};
        p_empty_nxt = 1'b1;
      end
      else if (a_tag == `SOP_TAG_IRW)
        set_nxt[`SOP_F_INDIR] = 1'b1;
      else if (!a_is_op)
        set_nxt[`SOP_F_INVOP] = 1'b1;
      else if (a_int[39] || (a_r[`SOP_MSIGN] && a_int[38:0] != 39'h0) || a_int[38:0] > `SOP_DYN_IDX_MAX)
        set_nxt[`SOP_F_INVIDX] = 1'b1;
      else
      begin
        a_full_nxt = 1'b0;
        b_full_nxt = 1'b0;
        psy_nxt = a_int[0] ? `SOP_SYL_ODD : 3'h0;
        pwi_nxt = a_int[20:1];
        p_empty_nxt = 1'b1;
      end
    end
    default:
      set_nxt[`SOP_F_INVOP] = 1'b1;
  endcase
end

// Bus side: read data is captured in the first access cycle so that a
// read that follows an operator at once still sees its result
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h0;
  end
  else
  begin
    pready <= psel && penable && !pready;
    pslverr <= psel && penable && !pready && !rd_ok;
    if (psel && penable && !pready)
      prdata <= (rd_ok && !pwrite) ? rd_val : 32'h0;
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    st_r <= ST_IDLE;
    a_r <= 51'h0;
    b_r <= 51'h0;
    y_r <= 51'h0;
    a_full_r <= 1'b0;
    b_full_r <= 1'b0;
    pwi_r <= 20'h0;
    psy_r <= 3'h0;
    p_empty_r <= 1'b1;
    op_r <= 8'h0;
    syl_r <= 16'h0;
    flag_r <= 6'h0;
  end
  else
  begin
    case (st_r)
      ST_IDLE:
      begin
        if (wr_en && paddr == `SOP_REG_CTRL)
        begin
          op_r <= pwdata[7:0];
          syl_r <= pwdata[23:8];
          st_r <= ST_EXEC;
        end
        if (wr_en && paddr == `SOP_REG_A_LO)
          a_r[31:0] <= pwdata;
        if (wr_en && paddr == `SOP_REG_A_HI)
        begin
          a_r[50:32] <= pwdata[18:0];
          a_full_r <= 1'b1;
        end
        if (wr_en && paddr == `SOP_REG_B_LO)
          b_r[31:0] <= pwdata;
        if (wr_en && paddr == `SOP_REG_B_HI)
        begin
          b_r[50:32] <= pwdata[18:0];
          b_full_r <= 1'b1;
        end
        if (wr_en && paddr == `SOP_REG_Y_LO)
          y_r[31:0] <= pwdata;
        if (wr_en && paddr == `SOP_REG_Y_HI)
          y_r[50:32] <= pwdata[18:0];
        if (wr_en && paddr == `SOP_REG_PROG)
        begin
          pwi_r <= pwdata[19:0];
          psy_r <= pwdata[22:20];
          p_empty_r <= pwdata[23];
        end
        if (wr_en && paddr == `SOP_REG_STAT)
        begin
          flag_r <= flag_r & ~pwdata[5:0];
          a_full_r <= pwdata[8];
          b_full_r <= pwdata[9];
        end
      end
      ST_EXEC:
      begin
        // A bus write cannot complete here: the earliest one needs two more edges
        a_r <= a_nxt;
        b_r <= b_nxt;
        y_r <= y_nxt;
        a_full_r <= a_full_nxt;
        b_full_r <= b_full_nxt;
        pwi_r <= pwi_nxt;
        psy_r <= psy_nxt;
        p_empty_r <= p_empty_nxt;
        flag_r <= flag_r | set_nxt;
        st_r <= ST_IDLE;
      end
      default:
        st_r <= ST_IDLE;
    endcase
  end
end

endmodule

// File: testbench/sop_exec_sva.sv
// Purpose: bus timing and status checks for sop_exec
// Assumes: one wait state per transfer, map ends at 0x20
// Notes: operator results are judged by the bench, not here
`timescale 1ns/1ps
module sop_exec_sva (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held past one cycle");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after the wait state");
  property p_setup; psel && !penable |=> !pready; endproperty
  a_setup: assert property (p_setup) else $error("answer in first access cycle");
  property p_qual; pready |-> psel && penable; endproperty
  a_qual: assert property (p_qual) else $error("answer without a transfer");
  property p_unm; pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
  property p_map; pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_wdat; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wdat: assert property (p_wdat) else $error("read data on a write");
  property p_idle; pready && !pwrite && paddr == 8'h1C |-> !prdata[10] && prdata[31:11] == 21'h0; endproperty
  a_idle: assert property (p_idle) else $error("status busy or reserved bits set");
endmodule

bind sop_exec sop_exec_sva i_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// File: testbench/sop_exec_tb.sv
// Purpose: self-checking bench for sop_exec
// Assumes: one operator per control write, results ready by the next read
// Notes: words go in low half first; the high half marks A or B full
`timescale 1ns/1ps
module sop_exec_tb;
  localparam logic [7:0] RA = 8'h00, RB = 8'h08, RY = 8'h10, RC = 8'h18, RS = 8'h1C, RP = 8'h20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  logic err;
  logic [50:0] v;
  sop_exec i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #4 pclk = ~pclk;
  // Whole run is under two thousand cycles; this only catches a hung handshake
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [50:0] g, input logic [50:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Values read right after the edge are the ones the edge sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ld(input logic [7:0] a, input logic [50:0] d);
    apb(1'b1, a, d[31:0]);
    apb(1'b1, a + 8'h04, {13'h0, d[50:32]});
  endtask
  task automatic rw(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    v[31:0] = q;
    apb(1'b0, a + 8'h04, 32'h0);
    v[50:32] = q[18:0];
  endtask
  task automatic op(input logic [7:0] o, input logic [15:0] s);
    apb(1'b1, RC, {8'h00, s, o});
  endtask
  task automatic xb(input logic [7:0] o, input logic [50:0] a, input logic [50:0] b);
    ld(RA, a);
    ld(RB, b);
    op(o, 16'h0000);
    rw(RB);
  endtask
  // Clearing the flags also empties A and B, so each case starts clean
  task automatic st(input logic [5:0] e);
    apb(1'b0, RS, 32'h0);
    chk("flags", q[5:0], e);
    apb(1'b1, RS, 32'h0000_003F);
  endtask
  task automatic pr(input logic [23:0] e, input logic [23:0] m);
    apb(1'b0, RP, 32'h0);
    chk("prog", q[23:0] & m, e);
  endtask
  function automatic logic [50:0] w(input logic [2:0] t, input logic s, input logic [6:0] e, input logic [38:0] m);
    return {t, 1'b0, s, e, m};
  endfunction
  task automatic t_reset();
    pr(24'h80_0000, 24'hFF_FFFF);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {err, q}, 33'h1_0000_0000);
    op(8'h90, 16'h0000);
    st(6'h08);
    $display("test reset done");
  endtask
  task automatic t_logic();
    logic [47:0] ia;
    logic [47:0] ib;
    logic [47:0] r;
    ia = 48'h5555_0000_0F0F;
    ib = 48'h3333_0000_00FF;
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 3; i++)
      begin
        r = (i == 0) ? ia & ib : (i == 1) ? ia | ib : ~(ia ^ ib);
        xb((i == 2) ? 8'h93 : 8'h90 + i[7:0], {j ? 3'h0 : 3'h2, ia}, {3'h0, ib});
        chk("logic", v, {j ? 3'h0 : 3'h2, r});
        st(6'h00);
      end
    ld(RA, {3'h2, ia});
    op(8'h92, 16'h0000);
    rw(RA);
    chk("negate", v, {3'h2, ~ia});
    xb(8'h94, {3'h0, ia}, {3'h0, ia});
    chk("same", v, 51'h1);
    xb(8'h94, {3'h2, ia}, {3'h0, ia});
    chk("same tags", v, 51'h0);
    st(6'h00);
    $display("test logic done");
  endtask
  task automatic t_cmp();
    logic [7:0] ops[6] = '{8'h8A, 8'h89, 8'h8C, 8'h8B, 8'h88, 8'h8D};
    logic [2:0] tt[6] = '{3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101};
    logic [50:0] bs[3];
    bs = '{w(0, 0, 0, 5), w(0, 0, 0, 3), w(0, 1, 0, 5)};
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < 3; k++)
      begin
        xb(ops[i], w(0, 0, 0, 3), bs[k]);
        chk("compare", v, {50'h0, tt[i][2 - k]});
        st(6'h00);
      end
    $display("test compare done");
  endtask
  task automatic t_int();
    xb(8'h87, 0, w(0, 0, 7'h41, 39'h95));
    chk("round up", v, w(0, 0, 0, 39'h13));
    xb(8'h87, 0, w(0, 0, 7'h41, 39'h94));
    chk("no round", v, w(0, 0, 0, 39'h12));
    st(6'h00);
    xb(8'h87, 0, w(0, 0, 7'h01, 39'h40_0000_0000));
    chk("kept", v, w(0, 0, 7'h01, 39'h40_0000_0000));
    st(6'h01);
    $display("test integerize done");
  endtask
  task automatic t_xfer();
    xb(8'hCC, 0, {3'h5, 7'h00, 1'b1, 20'h00123, 20'h0});
    chk("desc single", v, {3'h5, 7'h00, 1'b0, 20'h00246, 20'h0});
    xb(8'hCE, 0, v);
    chk("desc double", v, {3'h5, 7'h00, 1'b1, 20'h00123, 20'h0});
    ld(RY, 51'h7);
    xb(8'hCE, 0, w(0, 0, 0, 7));
    chk("ext tag", v, w(2, 0, 0, 7));
    rw(RY);
    chk("ext y", v, 51'h0);
    ld(RY, 51'h5);
    xb(8'hCE, 0, w(2, 0, 0, 7));
    chk("ext keep", v, w(2, 0, 0, 7));
    rw(RY);
    chk("ext keep y", v, 51'h5);
    st(6'h00);
    xb(8'hCC, 0, w(7, 0, 0, 7));
    st(6'h08);
    xb(8'hCE, 0, w(7, 0, 0, 7));
    st(6'h08);
    for (int i = 0; i < 2; i++)
    begin
      xb(8'hCC + i[7:0], 0, w(0, 0, 0, 1));
      chk("normalize", v, w(0, 0, 7'h4C, 39'h10_0000_0000));
    end
    ld(RY, 51'h80_0000_0000);
    xb(8'hCC, 0, w(2, 0, 0, 39'h10_0000_0000));
    st(6'h02);
    ld(RY, 51'h80_0000_0000);
    xb(8'hCD, 0, w(2, 0, 7'h40, 39'h10_0000_0000));
    st(6'h04);
    ld(RY, 51'h40_0000_0000);
    xb(8'hCC, 0, w(2, 0, 0, 39'h10_0000_0005));
    chk("truncated", v, w(0, 0, 0, 39'h10_0000_0005));
    ld(RY, 51'h40_0000_0000);
    xb(8'hCD, 0, w(2, 0, 0, 39'h10_0000_0005));
    chk("rounded", v, w(0, 0, 0, 39'h10_0000_0006));
    rw(RY);
    chk("y cleared", v, 51'h0);
    // All sevens plus one carries out: mantissa becomes one digit, exponent one up
    ld(RY, 51'h40_0000_0000);
    xb(8'hCD, 0, w(2, 0, 0, 39'h7F_FFFF_FFFF));
    chk("round carry", v, w(0, 0, 7'h01, 39'h10_0000_0000));
    st(6'h00);
    $display("test transfer done");
  endtask
  task automatic t_branch();
    apb(1'b1, RP, 32'h0);
    ld(RA, 0);
    op(8'hA0, 16'hA123);
    pr(24'hD0_0123, 24'hFF_FFFF);
    ld(RA, 0);
    op(8'hA1, 16'hA123);
    pr(24'h20_0124, 24'h7F_FFFF);
    ld(RA, 1);
    op(8'hA1, 16'h2005);
    pr(24'h90_0005, 24'hFF_FFFF);
    ld(RA, 0);
    op(8'hA2, 16'h8001);
    pr(24'hC0_0001, 24'hFF_FFFF);
    ld(RB, 0);
    ld(RA, w(0, 0, 0, 39'h3FFF));
    op(8'hA8, 16'h0000);
    pr(24'hB0_1FFF, 24'hFF_FFFF);
    ld(RB, 1);
    ld(RA, {3'h7, 32'h0, 3'h2, 13'h0123});
    op(8'hA9, 16'h0000);
    pr(24'h20_0123, 24'h7F_FFFF);
    ld(RB, 0);
    ld(RA, w(0, 0, 0, 39'h4000));
    op(8'hA9, 16'h0000);
    pr(24'h20_0123, 24'h7F_FFFF);
    ld(RB, 0);
    ld(RA, w(0, 0, 0, 39'h4000));
    op(8'hA8, 16'h0000);
    pr(24'h80_2000, 24'hFF_FFFF);
    ld(RB, 0);
    ld(RA, w(0, 0, 0, 39'h4001));
    op(8'hA8, 16'h0000);
    st(6'h10);
    // An indirect reference cannot be followed here, so it is flagged instead
    ld(RB, 0);
    ld(RA, {3'h1, 48'h0});
    op(8'hA8, 16'h0000);
    st(6'h20);
    $display("test branch done");
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_logic();
    t_cmp();
    t_int();
    t_xfer();
    t_branch();
    finish_test();
  end
endmodule
